// *** design/gcs_pkg.sv ***
// Package with offsets, field positions, codes and types of the block.
package gcs_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets.
  localparam logic [11:0] OFF_GENERAL_CONTROL = 12'h088;
  localparam logic [11:0] OFF_GENERAL_STATUS  = 12'h090;
  localparam logic [11:0] OFF_INTERRUPT_CAUSE = 12'h098;

  // Control enable bit positions; each also indexes its event source.
  localparam int unsigned CTRL_SWERR_EN_BIT = 0;
  localparam int unsigned CTRL_HALT_EN_BIT  = 1;
  localparam int unsigned CTRL_EVLOG_EN_BIT = 2;
  localparam int unsigned CTRL_W            = 3;
  localparam logic [2:0]  CTRL_RESET        = 3'h0;

  // Cause bit positions.
  localparam int unsigned CAUSE_SWERR_BIT = 0;
  localparam int unsigned CAUSE_HALT_BIT  = 4;
  localparam int unsigned CAUSE_EVLOG_BIT = 5;

  // Status field positions.
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_RTYPE_LSB = 2;

  // Device state codes.
  localparam logic [1:0] STATE_DISABLED  = 2'h0;
  localparam logic [1:0] STATE_ENABLED   = 2'h1;
  localparam logic [1:0] STATE_DISABLING = 2'h2;
  localparam logic [1:0] STATE_HALTED    = 2'h3;

  // Recovery reset type codes.
  localparam logic [1:0] RTYPE_RESET_CMD = 2'h0;
  localparam logic [1:0] RTYPE_FLR       = 2'h1;
  localparam logic [1:0] RTYPE_WARM      = 2'h2;
  localparam logic [1:0] RTYPE_COLD      = 2'h3;

  typedef enum logic [1:0] {
    GCS_DISABLED,
    GCS_ENABLED,
    GCS_DISABLING,
    GCS_HALTED
  } gcs_state_t;

  function automatic logic [1:0] gcs_code(input gcs_state_t s);
    logic [1:0] c;
    c = STATE_DISABLED;
    unique case (s)
      GCS_DISABLED:  c = STATE_DISABLED;
      GCS_ENABLED:   c = STATE_ENABLED;
      GCS_DISABLING: c = STATE_DISABLING;
      GCS_HALTED:    c = STATE_HALTED;
    endcase
    return c;
  endfunction

endpackage

// *** design/gcs_cause_bit.sv ***
// One sticky write-one-to-clear cause bit.
`timescale 1ns/1ps
module gcs_cause_bit (
  // Clock, reset and enable
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic ce,
  // Set and clear requests
  input  wire logic set,
  input  wire logic clr,
  // Stored bit
  output logic      q
);

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule // gcs_cause_bit

// *** design/gcs_regs.sv ***
// General control and status registers with device state and cause bits.
`timescale 1ns/1ps

module gcs_regs (
  // Clock, reset and enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  // Device commands and conditions
  input  wire logic        cmd_enable_device,
  input  wire logic        cmd_disable_device,
  input  wire logic        cmd_reset_device,
  input  wire logic        disable_done,
  input  wire logic        halt_error,
  input  wire logic [1:0]  halt_reset_type,
  // Event sources
  input  wire logic        event_log_written,
  input  wire logic        software_error_valid,
  // Device status outputs
  output logic [1:0]       device_state,
  output logic [1:0]       reset_type,
  output logic             enqueue_retry,
  output logic             work_queue_accept,
  output logic             msi0_req
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]       general_control;
  logic [31:0]      interrupt_cause;
  logic [2:0]       cause_q;
  gcs_pkg::gcs_state_t state;
  gcs_pkg::gcs_state_t next_state;
  logic             swerr_prev;
  logic             halt_entry;
  logic [2:0]       events;
  logic [2:0]       fire;
  logic             wr_ctrl;
  logic             wr_cause;
  assign wr_ctrl  = reg_wr && (reg_addr == gcs_pkg::OFF_GENERAL_CONTROL);
  assign wr_cause = reg_wr && (reg_addr == gcs_pkg::OFF_INTERRUPT_CAUSE);

  ////////////////////////////////////////////////////////////////////////////
  // Control word: only the three enables are stored.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      general_control <= gcs_pkg::CTRL_RESET;
    end else if (ce && wr_ctrl) begin
      general_control <= reg_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device state machine. A halt has priority over every command, and a
  // halted device leaves only by a reset command when type 00 allows it;
  // stronger types wait for the external reset.
  always_comb begin
    next_state = state;
    unique case (state)
      gcs_pkg::GCS_DISABLED: begin
        if (cmd_enable_device) begin
          next_state = gcs_pkg::GCS_ENABLED;
        end
      end
      gcs_pkg::GCS_ENABLED: begin
        if (cmd_disable_device || cmd_reset_device) begin
          next_state = gcs_pkg::GCS_DISABLING;
        end
      end
      gcs_pkg::GCS_DISABLING: begin
        if (disable_done) begin
          next_state = gcs_pkg::GCS_DISABLED;
        end
      end
      gcs_pkg::GCS_HALTED: begin
        if (cmd_reset_device && reset_type == gcs_pkg::RTYPE_RESET_CMD) begin
          next_state = gcs_pkg::GCS_DISABLING;
        end
      end
    endcase
    if (halt_error && state != gcs_pkg::GCS_HALTED) begin
      next_state = gcs_pkg::GCS_HALTED;
    end
  end
  assign halt_entry = (next_state == gcs_pkg::GCS_HALTED) &&
                      (state != gcs_pkg::GCS_HALTED);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state             <= gcs_pkg::GCS_DISABLED;
      device_state      <= gcs_pkg::STATE_DISABLED;
      enqueue_retry     <= 1'b1;
      work_queue_accept <= 1'b0;
    end else if (ce) begin
      state             <= next_state;
      device_state      <= gcs_pkg::gcs_code(next_state);
      enqueue_retry     <= next_state == gcs_pkg::GCS_DISABLED;
      work_queue_accept <= next_state == gcs_pkg::GCS_ENABLED;
    end
  end

  // The recovery type is captured as the device halts and kept until the device next enters disabled or reset.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reset_type <= gcs_pkg::RTYPE_RESET_CMD;
    end else if (ce) begin
      if (halt_entry) begin
        reset_type <= halt_reset_type;
      end else if (next_state == gcs_pkg::GCS_DISABLED) begin
        reset_type <= gcs_pkg::RTYPE_RESET_CMD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection and vector-0 requests.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      swerr_prev <= 1'b0;
    end else if (ce) begin
      swerr_prev <= software_error_valid;
    end
  end
  assign events[gcs_pkg::CTRL_SWERR_EN_BIT] = software_error_valid &&
                                              !swerr_prev;
  assign events[gcs_pkg::CTRL_HALT_EN_BIT]  = halt_entry;
  assign events[gcs_pkg::CTRL_EVLOG_EN_BIT] = event_log_written;
  // A disabled enable suppresses both the request and the cause bit.
  assign fire = events & general_control;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      msi0_req <= 1'b0;
    end else if (ce) begin
      msi0_req <= |fire;
    end
  end

  // Cause bits; all other cause positions stay zero here.
  always_comb begin
    interrupt_cause = 32'h0;
    interrupt_cause[gcs_pkg::CAUSE_SWERR_BIT] = cause_q[0];
    interrupt_cause[gcs_pkg::CAUSE_HALT_BIT]  = cause_q[1];
    interrupt_cause[gcs_pkg::CAUSE_EVLOG_BIT] = cause_q[2];
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_cause
      localparam int unsigned POS = (i == 0) ? gcs_pkg::CAUSE_SWERR_BIT :
                                    (i == 1) ? gcs_pkg::CAUSE_HALT_BIT :
                                               gcs_pkg::CAUSE_EVLOG_BIT;
      gcs_cause_bit u_bit (
        .mclk (mclk),
        .rstn (rstn),
        .ce   (ce),
        .set  (fire[i]),
        .clr  (wr_cause && reg_wdata[POS]),
        .q    (cause_q[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read port: one cycle latency; unmapped offsets read zero. The status
  // word has no write path at all.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata  <= 32'h0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (!reg_rd) begin
        reg_rdata <= 32'h0;
      end else if (reg_addr == gcs_pkg::OFF_GENERAL_CONTROL) begin
        reg_rdata <= {29'h0, general_control};
      end else if (reg_addr == gcs_pkg::OFF_GENERAL_STATUS) begin
        reg_rdata <= {28'h0, reset_type, device_state};
      end else if (reg_addr == gcs_pkg::OFF_INTERRUPT_CAUSE) begin
        reg_rdata <= interrupt_cause;
      end else begin
        reg_rdata <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_evlog_on;
    ce && event_log_written && general_control[2];
  endsequence
  sequence s_cause_evlog;
    msi0_req && cause_q[2];
  endsequence

  property p_evlog_fire;
    @(posedge mclk) disable iff (!rstn)
      s_evlog_on |=> s_cause_evlog;
  endproperty
  a_evlog_fire: assert property (p_evlog_fire)
    else $error("event log write did not raise interrupt and cause");

  property p_evlog_quiet;
    @(posedge mclk) disable iff (!rstn)
      ce && event_log_written && !general_control[2] && !cause_q[2]
      |=> !cause_q[2];
  endproperty
  a_evlog_quiet: assert property (p_evlog_quiet)
    else $error("event log cause set while its enable was low");

  property p_halt_fire;
    @(posedge mclk) disable iff (!rstn)
      ce && halt_error && state != gcs_pkg::GCS_HALTED && general_control[1]
      |=> msi0_req && cause_q[1] && device_state == gcs_pkg::STATE_HALTED;
  endproperty
  a_halt_fire: assert property (p_halt_fire)
    else $error("halt entry did not raise interrupt and cause");

  property p_swerr_fire;
    @(posedge mclk) disable iff (!rstn)
      ce && software_error_valid && !swerr_prev && general_control[0]
      |=> msi0_req && cause_q[0];
  endproperty
  a_swerr_fire: assert property (p_swerr_fire)
    else $error("software error edge did not raise interrupt");

  property p_all_off_quiet;
    @(posedge mclk) disable iff (!rstn)
      ce && general_control == 3'h0 |=> !msi0_req;
  endproperty
  a_all_off_quiet: assert property (p_all_off_quiet)
    else $error("interrupt raised with every enable low");

  property p_halt_rtype;
    @(posedge mclk) disable iff (!rstn)
      ce && halt_entry |=> reset_type == $past(halt_reset_type) ##1
      (!ce || device_state != gcs_pkg::STATE_HALTED ||
       reset_type == $past(reset_type));
  endproperty
  a_halt_rtype: assert property (p_halt_rtype)
    else $error("reset type not captured or not held in halt");

  property p_state_outputs;
    @(posedge mclk) disable iff (!rstn)
      (enqueue_retry == (device_state == gcs_pkg::STATE_DISABLED)) &&
      (work_queue_accept == (device_state == gcs_pkg::STATE_ENABLED));
  endproperty
  a_state_outputs: assert property (p_state_outputs)
    else $error("enqueue retry or acceptance disagrees with state");

  property p_status_read;
    @(posedge mclk) disable iff (!rstn)
      ce && reg_rd && reg_addr == gcs_pkg::OFF_GENERAL_STATUS
      |=> reg_rvalid && reg_rdata == {28'h0, $past(reset_type),
                                      $past(device_state)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read data wrong");

  property p_cause_clear;
    @(posedge mclk) disable iff (!rstn)
      ce && wr_cause && reg_wdata[gcs_pkg::CAUSE_EVLOG_BIT] && !fire[2]
      |=> !cause_q[2];
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("cause bit not cleared by writing one");

  property p_ctrl_read;
    @(posedge mclk) disable iff (!rstn)
      ce && reg_rd && reg_addr == gcs_pkg::OFF_GENERAL_CONTROL
      |=> reg_rdata[31:3] == 29'h0 && reg_rdata[2:0] == $past(general_control);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read data wrong");

endmodule // gcs_regs

// *** verif/gcs_regs_tb.sv ***
// Self-checking testbench of the general control and status registers.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gcs_regs_tb;
  logic        mclk;
  logic        rstn;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [5:0]  pulses;
  logic [1:0]  halt_reset_type;
  logic        software_error_valid;
  logic [1:0]  device_state;
  logic [1:0]  reset_type;
  logic        enqueue_retry;
  logic        work_queue_accept;
  logic        msi0_req;
  int          bad_count;
  int          checks;
  int          cycles;
  localparam logic [11:0] CTL = gcs_pkg::OFF_GENERAL_CONTROL;
  localparam logic [11:0] STS = gcs_pkg::OFF_GENERAL_STATUS;
  localparam logic [11:0] CAU = gcs_pkg::OFF_INTERRUPT_CAUSE;
  // Pulse vector order: event log, halt, done, reset, disable, enable.
  localparam logic [5:0] P_EVL = 6'h20;
  localparam logic [5:0] P_HLT = 6'h10;
  localparam logic [5:0] P_DON = 6'h08;
  localparam logic [5:0] P_RST = 6'h04;
  localparam logic [5:0] P_DIS = 6'h02;
  localparam logic [5:0] P_ENA = 6'h01;

  gcs_regs i_gcs_regs (
    .mclk                 (mclk),
    .rstn                 (rstn),
    .ce                   (ce),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .reg_rvalid           (reg_rvalid),
    .cmd_enable_device    (pulses[0]),
    .cmd_disable_device   (pulses[1]),
    .cmd_reset_device     (pulses[2]),
    .disable_done         (pulses[3]),
    .halt_error           (pulses[4]),
    .halt_reset_type      (halt_reset_type),
    .event_log_written    (pulses[5]),
    .software_error_valid (software_error_valid),
    .device_state         (device_state),
    .reset_type           (reset_type),
    .enqueue_retry        (enqueue_retry),
    .work_queue_accept    (work_queue_accept),
    .msi0_req             (msi0_req)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang is cut short at 5000 cycles, far beyond the 140 or so cycles the run needs.
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask

  // Outputs of the pulsed edge are settled at the negedge this returns on.
  task automatic pulse(input logic [5:0] p);
    @(negedge mclk);
    pulses = p;
    @(negedge mclk);
    pulses = 6'h00;
  endtask

  task automatic do_reset();
    @(negedge mclk);
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    pulses = 6'h00;
    halt_reset_type = 2'h0;
    software_error_valid = 1'b0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    rd(CTL, 32'h0);
    rd(STS, 32'h0);
    rd(CAU, 32'h0);
    `CHK(enqueue_retry, 1'b1)
    `CHK(work_queue_accept, 1'b0)
    wr(CTL, 32'hffff_ffff);
    rd(CTL, 32'h0000_0007);
    wr(STS, 32'hffff_ffff);
    rd(STS, 32'h0);
    rd(12'h0a0, 32'h0);
    // Event log interrupt, then write-one-to-clear of its cause.
    pulse(P_EVL);
    `CHK(msi0_req, 1'b1)
    @(negedge mclk);
    `CHK(msi0_req, 1'b0)
    rd(CAU, 32'h0000_0020);
    wr(CAU, 32'h0000_0020);
    rd(CAU, 32'h0);
    // A low clock enable freezes every flop, events and writes alike.
    wr(CTL, 32'h0000_0004);
    ce = 1'b0;
    pulse(P_EVL);
    wr(CTL, 32'h0);
    `CHK(msi0_req, 1'b0)
    ce = 1'b1;
    rd(CTL, 32'h0000_0004);
    rd(CAU, 32'h0);
    // With every enable off, nothing fires; then the software error enable alone is set and its edge fires.
    wr(CTL, 32'h0);
    pulse(P_EVL);
    `CHK(msi0_req, 1'b0)
    @(negedge mclk);
    software_error_valid = 1'b1;
    @(negedge mclk);
    `CHK(msi0_req, 1'b0)
    rd(CAU, 32'h0);
    software_error_valid = 1'b0;
    wr(CTL, 32'h0000_0001);
    @(negedge mclk);
    software_error_valid = 1'b1;
    @(negedge mclk);
    `CHK(msi0_req, 1'b1)
    @(negedge mclk);
    `CHK(msi0_req, 1'b0)
    rd(CAU, 32'h0000_0001);
    wr(CAU, 32'h0000_0001);
    software_error_valid = 1'b0;
    // Device state walk.
    pulse(P_ENA);
    `CHK(device_state, gcs_pkg::STATE_ENABLED)
    `CHK(work_queue_accept, 1'b1)
    `CHK(enqueue_retry, 1'b0)
    rd(STS, 32'h0000_0001);
    pulse(P_DIS);
    `CHK(device_state, gcs_pkg::STATE_DISABLING)
    `CHK(work_queue_accept, 1'b0)
    rd(STS, 32'h0000_0002);
    pulse(P_DON);
    `CHK(device_state, gcs_pkg::STATE_DISABLED)
    `CHK(enqueue_retry, 1'b1)
    pulse(P_ENA);
    pulse(P_RST);
    `CHK(device_state, gcs_pkg::STATE_DISABLING)
    pulse(P_DON);
    // Halt entry with its enable off.
    wr(CTL, 32'h0);
    pulse(P_HLT);
    `CHK(msi0_req, 1'b0)
    rd(CAU, 32'h0);
    do_reset();
    // Halt entry with every reset type code.
    for (int t = 0; t < 4; t++) begin
      wr(CTL, 32'h0000_0002);
      halt_reset_type = 2'(t);
      pulse(P_HLT);
      `CHK(msi0_req, 1'b1)
      `CHK(device_state, gcs_pkg::STATE_HALTED)
      `CHK(reset_type, 2'(t))
      rd(STS, {28'h0, 2'(t), 2'h3});
      rd(CAU, 32'h0000_0010);
      // A halt error while already halted is not a new entry.
      pulse(P_HLT);
      `CHK(msi0_req, 1'b0)
      if (t == 0) begin
        pulse(P_RST);
        `CHK(device_state, gcs_pkg::STATE_DISABLING)
        pulse(P_DON);
        `CHK(reset_type, gcs_pkg::RTYPE_RESET_CMD)
        rd(STS, 32'h0);
      end else begin
        // A reset command cannot lift a halt that needs a stronger reset.
        pulse(P_RST);
        `CHK(device_state, gcs_pkg::STATE_HALTED)
      end
      do_reset();
      `CHK(device_state, gcs_pkg::STATE_DISABLED)
      `CHK(reset_type, gcs_pkg::RTYPE_RESET_CMD)
    end
    finish_test();
  end
endmodule // gcs_regs_tb
